/* common/fpm_pkg.sv */
// Constants and types shared by the flash protect and memory select block
package fpm_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 25;
	localparam int RESET_RECOVER_US = 25;
	localparam int RESET_RECOVER_CYC = RESET_RECOVER_US * CLK_MHZ;
	localparam int SMALL_RESET_MS = 2;
	localparam int SMALL_RESET_CYC = SMALL_RESET_MS * 1000 * CLK_MHZ;
	localparam int PROG_CYC = 250;
	localparam int ERASE_CYC = 25000;
	localparam int TIMER_W = 16;

	// Sector counts
	localparam int MAIN_SECTORS = 8;
	localparam int SEC_SECTORS = 4;
	localparam int ALL_SECTORS = 12;

	// Register offsets inside the register space (low address byte)
	localparam logic [7:0] OFS_MAIN_LOCK = 8'hc0;
	localparam logic [7:0] OFS_SEC_LOCK = 8'hc2;
	localparam logic [7:0] OFS_SPACE_MAP = 8'he2;

	// Space map fields and reset value
	localparam int MAP_RAM_CODE = 0;
	localparam int MAP_SEC_CODE = 1;
	localparam int MAP_MAIN_CODE = 2;
	localparam int MAP_SEC_DATA = 3;
	localparam int MAP_MAIN_DATA = 4;
	localparam logic [7:0] MAP_USED = 8'h1f;
	localparam logic [7:0] MAP_INIT_DEFAULT = 8'h0c;

	// Secondary lock status fields
	localparam int SEC_LOCK_SECURITY = 7;

	// Flash status byte fields
	localparam int STAT_TOGGLE = 6;
	localparam int STAT_ERROR = 5;

	// Command cycle addresses and data
	localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
	localparam logic [11:0] UNLOCK_ADDR2 = 12'haaa;
	localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
	localparam logic [7:0] CMD_RESET = 8'hf0;

	// Flash operating modes
	typedef enum logic [2:0] {
		FPM_READ,
		FPM_PROGRAM,
		FPM_SECTOR_ERASE,
		FPM_BULK_ERASE,
		FPM_ERROR,
		FPM_RECOVER
	} fpm_mode_t;

	// Command decode progress
	typedef enum logic [2:0] {
		FPM_S_IDLE,
		FPM_S_UNLOCK1,
		FPM_S_UNLOCK2,
		FPM_S_PROG_DATA,
		FPM_S_ERASE1,
		FPM_S_ERASE2,
		FPM_S_ERASE3
	} fpm_step_t;
endpackage

/* hdl/fpm_top.sv */
// Flash sector protection, flash reset handling and memory select priority
// Function
// RULE1: Per-sector protection blocks program and erase
// RULE2: Bus reads protection bits, writes change nothing
// RULE3: Protected program/erase silently ignored, data kept
// RULE4: Main lock status bit i is sector i
// RULE5: Secondary lock bits 3..0 are sectors 3..0
// RULE6: Secondary lock bit 7 shows security lock
// RULE7: Reset is one write, optional two unlocks
// RULE8: Host issues reset after status or error
// RULE9: Reset ignored during program or bulk erase
// RULE10: Small variant reset takes milliseconds, aborts erase
// RULE11: Large variant reset immediate, 25 us on error
// RULE12: Large variant reset aborts erase within 25 us
// RULE13: Reset pin aborts everything, 25 us if busy
// RULE14: Host holds reset pulse at least 25 us
// RULE15: SRAM answers only while its select high
// RULE16: Secondary sector beats overlapping main sector
// RULE17: SRAM or register space beats any flash
// RULE18: Space map bits enable code/data per memory
// RULE19: Software writes zeros to map bits 7..5
// RULE20: Space map loads initial value, then writable
// RULE21: Fetch strobe qualifies code, read strobe data
// RULE22: Software uses map value 0Ch for split spaces
// RULE23: Error flag set on timeout or bad program
// RULE24: Protection checked at decode before algorithm start
// RULE25: No select means no drive, no operation
`timescale 1ns/1ps

module fpm_top #(
	parameter logic [7:0] MAP_INIT = fpm_pkg::MAP_INIT_DEFAULT,
	parameter bit SMALL_VARIANT = 1'b0,
	parameter int SMALL_RESET_CYC = fpm_pkg::SMALL_RESET_CYC,
	parameter int ERASE_CYC = fpm_pkg::ERASE_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reset_pulse,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic program_fetch_strobe,
	input wire logic [7:0] main_sector_select,
	input wire logic [3:0] secondary_sector_select,
	input wire logic ram_select,
	input wire logic register_space_select,
	input wire logic [7:0] main_protect_cfg,
	input wire logic [3:0] secondary_protect_cfg,
	input wire logic security_lock,
	input wire logic [7:0] mem_rdata,
	input wire logic algo_error,
	output logic ram_enable,
	output logic [7:0] main_sector_enable,
	output logic [3:0] secondary_sector_enable,
	output logic [7:0] rdata,
	output logic data_oe,
	output logic prog_start,
	output logic erase_start,
	output logic [11:0] erase_mask,
	output logic [15:0] op_addr,
	output logic [7:0] op_data,
	output logic flash_busy,
	output logic flash_read_mode,
	output logic error_flag_bit
);
	localparam int RECOVER_CYC = fpm_pkg::RESET_RECOVER_CYC;
	localparam int PROG_CYC = fpm_pkg::PROG_CYC;

	typedef struct packed {
		fpm_pkg::fpm_mode_t mode;
		fpm_pkg::fpm_step_t step;
		logic [fpm_pkg::TIMER_W-1:0] timer;
		logic err;
		logic toggle;
		logic [7:0] space_map;
		logic [7:0] rdata;
		logic data_oe;
		logic prog_start;
		logic erase_start;
		logic [11:0] erase_mask;
		logic [15:0] op_addr;
		logic [7:0] op_data;
	} fpm_state_t;

	fpm_state_t state_r;
	fpm_state_t state_nxt;

	// Sector index of a one-hot flash select, secondary sectors above main
	function automatic logic [3:0] sector_index(input logic [11:0] onehot);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < fpm_pkg::ALL_SECTORS; i++) begin
			if (onehot[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// Cycle count truncated to timer width
	function automatic logic [fpm_pkg::TIMER_W-1:0] cyc(input int n);
		return fpm_pkg::TIMER_W'(n);
	endfunction

	logic data_access;
	logic code_access;
	logic any_access;
	logic ram_hit;
	logic reg_hit;
	logic sec_ok;
	logic main_ok;
	logic sec_hit;
	logic main_hit;
	logic flash_hit;
	logic [11:0] flash_sel;
	logic [11:0] protect_vec;
	logic target_protected;
	logic [11:0] unprotected;
	logic [11:0] cmd_addr;
	logic busy_algo;

	// Strobe qualification: code by fetch strobe, data by read or write
	assign data_access = rd_strobe | wr_strobe; // RULE21
	assign code_access = program_fetch_strobe; // RULE21
	assign any_access = data_access | code_access;

	// Space map decides which memory each kind of access may reach
	assign sec_ok = (data_access & state_r.space_map[fpm_pkg::MAP_SEC_DATA])
		| (code_access & state_r.space_map[fpm_pkg::MAP_SEC_CODE]); // RULE18
	assign main_ok = (data_access & state_r.space_map[fpm_pkg::MAP_MAIN_DATA])
		| (code_access & state_r.space_map[fpm_pkg::MAP_MAIN_CODE]); // RULE18

	// SRAM and register space sit on top, then secondary, then main flash
	assign ram_hit = ram_select & (data_access
		| (code_access & state_r.space_map[fpm_pkg::MAP_RAM_CODE])); // RULE15
	assign reg_hit = register_space_select & data_access;
	// Priority follows the selects, so a map-disabled winner still shadows lower memories
	assign sec_hit = (|secondary_sector_select) & sec_ok & ~ram_select
		& ~register_space_select; // RULE17
	assign main_hit = (|main_sector_select) & main_ok & ~(|secondary_sector_select)
		& ~ram_select & ~register_space_select; // RULE16
	assign flash_hit = sec_hit | main_hit;

	assign ram_enable = ram_hit; // RULE15
	assign secondary_sector_enable = sec_hit ? secondary_sector_select : 4'h0;
	assign main_sector_enable = main_hit ? main_sector_select : 8'h00;
	assign flash_sel = {secondary_sector_enable, main_sector_enable};

	// Protection comes only from configuration pins, never the bus
	assign protect_vec = {secondary_protect_cfg, main_protect_cfg}; // RULE1 RULE2
	assign target_protected = |(flash_sel & protect_vec); // RULE24
	assign unprotected = ~protect_vec;
	assign cmd_addr = addr[11:0];
	assign busy_algo = (state_r.mode == fpm_pkg::FPM_PROGRAM)
		| (state_r.mode == fpm_pkg::FPM_BULK_ERASE);

	// Next state: register access, command decode, flash mode timing
	always_comb begin
		state_nxt = state_r;
		state_nxt.prog_start = 1'b0;
		state_nxt.erase_start = 1'b0;
		state_nxt.data_oe = 1'b0;

		// Reads answer one cycle after the strobe; nothing driven without a hit
		if (rd_strobe | code_access) begin
			if (reg_hit & rd_strobe) begin
				state_nxt.data_oe = 1'b1;
				unique case (addr[7:0])
					fpm_pkg::OFS_MAIN_LOCK: state_nxt.rdata = main_protect_cfg; // RULE4
					fpm_pkg::OFS_SEC_LOCK: begin
						state_nxt.rdata = 8'h00;
						state_nxt.rdata[3:0] = secondary_protect_cfg; // RULE5
						state_nxt.rdata[fpm_pkg::SEC_LOCK_SECURITY] = security_lock; // RULE6
					end
					fpm_pkg::OFS_SPACE_MAP: state_nxt.rdata = state_r.space_map;
					default: state_nxt.rdata = 8'h00;
				endcase
			end else if (flash_hit & (state_r.mode != fpm_pkg::FPM_READ)) begin
				// Status byte while an algorithm runs, an error stands or a reset recovery runs
				state_nxt.data_oe = 1'b1;
				state_nxt.rdata = 8'h00;
				state_nxt.rdata[fpm_pkg::STAT_TOGGLE] = state_r.toggle;
				state_nxt.rdata[fpm_pkg::STAT_ERROR] = state_r.err;
				state_nxt.toggle = ~state_r.toggle;
			end else if (ram_hit | flash_hit) begin
				// Protected sectors keep their data, so verify reads it back
				state_nxt.data_oe = 1'b1; // RULE3
				state_nxt.rdata = mem_rdata;
			end // RULE25
		end

		// Space map write; lock status registers ignore writes
		if (reg_hit & wr_strobe & (addr[7:0] == fpm_pkg::OFS_SPACE_MAP)) begin
			state_nxt.space_map = wdata & fpm_pkg::MAP_USED; // RULE20 RULE19
		end // RULE2

		// Algorithm timer and completion
		if (state_r.timer != cyc(0)) begin
			state_nxt.timer = state_r.timer - cyc(1);
		end
		unique case (state_r.mode)
			fpm_pkg::FPM_PROGRAM, fpm_pkg::FPM_SECTOR_ERASE, fpm_pkg::FPM_BULK_ERASE: begin
				if (algo_error) begin
					state_nxt.err = 1'b1; // RULE23
					state_nxt.mode = fpm_pkg::FPM_ERROR;
					state_nxt.timer = cyc(0);
				end else if (state_r.timer == cyc(1)) begin
					state_nxt.mode = fpm_pkg::FPM_READ;
				end
			end
			fpm_pkg::FPM_RECOVER: begin
				if (state_r.timer == cyc(1)) begin
					state_nxt.mode = fpm_pkg::FPM_READ;
					state_nxt.err = 1'b0;
				end
			end
			default: ;
		endcase

		// Command decode on writes that reach a flash sector
		if (wr_strobe & flash_hit) begin
			state_nxt.step = fpm_pkg::FPM_S_IDLE;
			if (wdata == fpm_pkg::CMD_RESET) begin
				// Reset may follow the unlock pair or stand alone
				if (busy_algo) begin
					state_nxt.mode = state_r.mode; // RULE9
				end else if (SMALL_VARIANT) begin
					if (state_r.mode != fpm_pkg::FPM_READ) begin
						state_nxt.mode = fpm_pkg::FPM_RECOVER; // RULE10
						state_nxt.timer = cyc(SMALL_RESET_CYC);
					end
				end else if ((state_r.mode == fpm_pkg::FPM_SECTOR_ERASE) | state_r.err) begin
					state_nxt.mode = fpm_pkg::FPM_RECOVER; // RULE11 RULE12
					state_nxt.timer = cyc(RECOVER_CYC);
				end else begin
					state_nxt.mode = fpm_pkg::FPM_READ; // RULE11
				end // RULE7
			end else if (state_r.mode == fpm_pkg::FPM_READ) begin
				unique case (state_r.step)
					fpm_pkg::FPM_S_IDLE, fpm_pkg::FPM_S_ERASE1: begin
						if (cmd_addr == fpm_pkg::UNLOCK_ADDR1 && wdata == fpm_pkg::UNLOCK_DATA1) begin
							state_nxt.step = (state_r.step == fpm_pkg::FPM_S_IDLE)
								? fpm_pkg::FPM_S_UNLOCK1 : fpm_pkg::FPM_S_ERASE2;
						end
					end
					fpm_pkg::FPM_S_UNLOCK1: begin
						if (cmd_addr == fpm_pkg::UNLOCK_ADDR2 && wdata == fpm_pkg::UNLOCK_DATA2) begin
							state_nxt.step = fpm_pkg::FPM_S_UNLOCK2;
						end
					end
					fpm_pkg::FPM_S_UNLOCK2: begin
						if (wdata == fpm_pkg::CMD_PROGRAM) begin
							state_nxt.step = fpm_pkg::FPM_S_PROG_DATA;
						end else if (wdata == fpm_pkg::CMD_ERASE_SETUP) begin
							state_nxt.step = fpm_pkg::FPM_S_ERASE1;
						end
					end
					fpm_pkg::FPM_S_ERASE2: begin
						if (cmd_addr == fpm_pkg::UNLOCK_ADDR2 && wdata == fpm_pkg::UNLOCK_DATA2) begin
							state_nxt.step = fpm_pkg::FPM_S_ERASE3;
						end
					end
					fpm_pkg::FPM_S_PROG_DATA: begin
						// Protection checked before the algorithm is started
						if (!target_protected) begin // RULE24 RULE1 RULE3
							state_nxt.mode = fpm_pkg::FPM_PROGRAM;
							state_nxt.timer = cyc(PROG_CYC);
							state_nxt.prog_start = 1'b1;
							state_nxt.op_addr = addr;
							state_nxt.op_data = wdata;
						end
					end
					fpm_pkg::FPM_S_ERASE3: begin
						if (wdata == fpm_pkg::CMD_SECTOR_ERASE && !target_protected) begin
							state_nxt.mode = fpm_pkg::FPM_SECTOR_ERASE; // RULE24 RULE1
							state_nxt.timer = cyc(ERASE_CYC);
							state_nxt.erase_start = 1'b1;
							state_nxt.erase_mask = 12'h001 << sector_index(flash_sel);
						end else if (wdata == fpm_pkg::CMD_BULK_ERASE && (|unprotected)) begin
							// Bulk erase skips protected sectors
							state_nxt.mode = fpm_pkg::FPM_BULK_ERASE; // RULE1
							state_nxt.timer = cyc(ERASE_CYC);
							state_nxt.erase_start = 1'b1;
							state_nxt.erase_mask = unprotected;
						end
					end
					default: state_nxt.step = fpm_pkg::FPM_S_IDLE;
				endcase
			end
		end

		// Reset pin overrides everything; a running algorithm needs recovery
		if (reset_pulse) begin
			state_nxt.step = fpm_pkg::FPM_S_IDLE;
			state_nxt.prog_start = 1'b0;
			state_nxt.erase_start = 1'b0;
			if (busy_algo | (state_r.mode == fpm_pkg::FPM_SECTOR_ERASE)
				| (state_r.mode == fpm_pkg::FPM_RECOVER)) begin
				state_nxt.mode = fpm_pkg::FPM_RECOVER; // RULE13
				state_nxt.timer = cyc(RECOVER_CYC);
			end else begin
				state_nxt.mode = fpm_pkg::FPM_READ; // RULE13
				state_nxt.timer = cyc(0);
			end
			state_nxt.err = 1'b0;
		end
	end

	// State register; the space map starts from its configured value
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r.mode <= fpm_pkg::FPM_READ;
			state_r.step <= fpm_pkg::FPM_S_IDLE;
			state_r.timer <= '0;
			state_r.err <= 1'b0;
			state_r.toggle <= 1'b0;
			state_r.space_map <= MAP_INIT & fpm_pkg::MAP_USED; // RULE20
			state_r.rdata <= 8'h00;
			state_r.data_oe <= 1'b0;
			state_r.prog_start <= 1'b0;
			state_r.erase_start <= 1'b0;
			state_r.erase_mask <= 12'h000;
			state_r.op_addr <= 16'h0000;
			state_r.op_data <= 8'h00;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register
	assign rdata = state_r.rdata;
	assign data_oe = state_r.data_oe; // RULE25
	assign prog_start = state_r.prog_start;
	assign erase_start = state_r.erase_start;
	assign erase_mask = state_r.erase_mask;
	assign op_addr = state_r.op_addr;
	assign op_data = state_r.op_data;
	assign flash_busy = state_r.mode != fpm_pkg::FPM_READ;
	assign flash_read_mode = state_r.mode == fpm_pkg::FPM_READ;
	assign error_flag_bit = state_r.err; // RULE23
endmodule // fpm_top

/* test/fpm_mcu_model.sv */
// Microcontroller bus model driving one-cycle strobes toward the block
`timescale 1ns/1ps

module fpm_mcu_model (
	input wire logic clock,
	output logic [15:0] addr,
	output logic [7:0] wdata,
	output logic wr_strobe,
	output logic rd_strobe,
	output logic program_fetch_strobe
);
	// Bus idles with no strobe
	initial begin
		addr = 16'h0000;
		wdata = 8'h00;
		{wr_strobe, rd_strobe, program_fetch_strobe} = 3'h0;
	end

	// One access: k 0 write, 1 data read, 2 code fetch
	task bus(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		{wr_strobe, rd_strobe, program_fetch_strobe} <= {k == 2'd0, k == 2'd1, k == 2'd2};
		@(posedge clock);
		{wr_strobe, rd_strobe, program_fetch_strobe} <= 3'h0;
		// Released bus is inverted so a stale value can never look valid
		addr <= ~a;
		wdata <= ~d;
	endtask
endmodule // fpm_mcu_model

/* test/fpm_top_asserts.sv */
// Port-level assertion checker for the flash protect and memory select block
`timescale 1ns/1ps

module fpm_top_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic reset_pulse,
	input wire logic [15:0] addr,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic program_fetch_strobe,
	input wire logic [7:0] main_sector_select,
	input wire logic [3:0] secondary_sector_select,
	input wire logic ram_select,
	input wire logic register_space_select,
	input wire logic [7:0] main_protect_cfg,
	input wire logic ram_enable,
	input wire logic [7:0] main_sector_enable,
	input wire logic [3:0] secondary_sector_enable,
	input wire logic [7:0] rdata,
	input wire logic data_oe,
	input wire logic prog_start,
	input wire logic erase_start,
	input wire logic flash_busy,
	input wire logic flash_read_mode
);
	// Single clock domain, all checks idle during reset
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	main_lock_read_a: assert property (
		rd_strobe && register_space_select && addr[7:0] == fpm_pkg::OFS_MAIN_LOCK
		|=> data_oe && rdata == $past(main_protect_cfg)) else $error("main lock read wrong");
	ram_gated_a: assert property (ram_enable |-> ram_select) else $error("ram without select");
	sec_wins_a: assert property (
		(|secondary_sector_select) |-> main_sector_enable == 8'h00) else $error("main beat sec");
	io_wins_a: assert property (
		ram_select || register_space_select
		|-> main_sector_enable == 8'h00 && secondary_sector_enable == 4'h0)
		else $error("flash beat ram or io");
	no_select_a: assert property (
		(rd_strobe || program_fetch_strobe || wr_strobe) && !ram_select && !register_space_select
		&& main_sector_select == 8'h00 && secondary_sector_select == 4'h0
		|=> !data_oe && !prog_start && !erase_start) else $error("access without select");
	pin_idle_a: assert property (
		reset_pulse && !flash_busy |=> flash_read_mode && !prog_start && !erase_start)
		else $error("pin reset left read mode");
	pin_recover_a: assert property (
		$fell(reset_pulse) |-> ##[0:626] flash_read_mode) else $error("no read mode after pin");
	start_busy_a: assert property (
		(prog_start || erase_start) && !reset_pulse |=> flash_busy) else $error("start not busy");
endmodule // fpm_top_chk

bind fpm_top fpm_top_chk fpm_top_chk_inst (.clock, .rst, .reset_pulse, .addr, .wr_strobe,
	.rd_strobe, .program_fetch_strobe, .main_sector_select, .secondary_sector_select,
	.ram_select, .register_space_select, .main_protect_cfg, .ram_enable, .main_sector_enable,
	.secondary_sector_enable, .rdata, .data_oe, .prog_start, .erase_start, .flash_busy,
	.flash_read_mode);

/* test/fpm_top_tb_top.sv */
// Self-checking bench for the flash protect and memory select block
`timescale 1ns/1ps

module fpm_top_tb_top;
	logic clock = 1'b0, rst = 1'b1, reset_pulse = 1'b0, algo_error = 1'b0, security_lock = 1'b0;
	logic ram_select = 1'b0, register_space_select = 1'b0, wr_strobe, rd_strobe;
	logic program_fetch_strobe, ram_enable, data_oe, prog_start, erase_start;
	logic flash_busy, flash_read_mode, error_flag_bit;
	logic [15:0] addr, op_addr;
	logic [7:0] wdata, rdata, op_data, main_sector_enable, last_mem, mem_rdata = 8'h00;
	logic [7:0] main_sector_select = 8'h00, main_protect_cfg = 8'h00;
	logic [3:0] secondary_sector_select = 4'h0, secondary_protect_cfg = 4'h0;
	logic [3:0] secondary_sector_enable;
	logic [11:0] erase_mask;
	logic [7:0] m, mm;
	logic [3:0] ss;
	logic r, f;
	int seed = 32'h0bca, mismatches = 0, n_compared = 0, n_prog = 0;

	fpm_top #(.SMALL_RESET_CYC(20), .ERASE_CYC(40)) fpm_top_inst (.clock, .rst, .reset_pulse,
		.addr, .wdata, .wr_strobe, .rd_strobe, .program_fetch_strobe, .main_sector_select,
		.secondary_sector_select, .ram_select, .register_space_select, .main_protect_cfg,
		.secondary_protect_cfg, .security_lock, .mem_rdata, .algo_error, .ram_enable,
		.main_sector_enable, .secondary_sector_enable, .rdata, .data_oe, .prog_start,
		.erase_start, .erase_mask, .op_addr, .op_data, .flash_busy, .flash_read_mode,
		.error_flag_bit);
	fpm_mcu_model fpm_mcu_model_inst (.clock, .addr, .wdata, .wr_strobe, .rd_strobe,
		.program_fetch_strobe);

	always #20 clock = ~clock;

	// Array data changes every cycle so a stale capture shows up
	always @(posedge clock) begin
		mem_rdata <= $random(seed);
		if (rd_strobe || program_fetch_strobe) last_mem <= mem_rdata;
		if (prog_start === 1'b1) n_prog++;
	end

	// Cuts a hang short well beyond the expected run length
	initial begin
		#(40 * 40000);
		mismatches++;
		stop_test();
	end

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Winner order is ram, then secondary, then main; fetches obey the map bits
	function logic exp_oe(logic [4:0] mp, logic fe, logic rs, logic [3:0] s, logic [7:0] ms);
		if (rs) return fe ? mp[0] : 1'b1;
		if (|s) return fe ? mp[1] : mp[3];
		if (|ms) return fe ? mp[2] : mp[4];
		return 1'b0;
	endfunction

	task sel(input logic [7:0] ms, input logic [3:0] s, input logic rs, input logic io);
		@(posedge clock);
		{main_sector_select, secondary_sector_select, ram_select, register_space_select} <=
			{ms, s, rs, io};
	endtask

	task acc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
		fpm_mcu_model_inst.bus(k, a, d);
		#1;
	endtask

	task reg_io(input logic [1:0] k, input logic [7:0] ofs, input logic [7:0] d);
		sel(8'h00, 4'h0, 1'b0, 1'b1);
		acc(k, {8'h00, ofs}, d);
		if (k == 2'd1) chk("register", rdata, d);
	endtask

	task unlock();
		acc(2'd0, {4'h0, fpm_pkg::UNLOCK_ADDR1}, fpm_pkg::UNLOCK_DATA1);
		acc(2'd0, {4'h0, fpm_pkg::UNLOCK_ADDR2}, fpm_pkg::UNLOCK_DATA2);
	endtask

	task wait_busy(input int lo, input int hi);
		repeat (lo) @(posedge clock);
		#1 chk("busy", flash_busy, 1'b1);
		repeat (hi - lo) @(posedge clock);
		#1 chk("read mode", flash_read_mode, 1'b1);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		reg_io(2'd1, fpm_pkg::OFS_SPACE_MAP, fpm_pkg::MAP_INIT_DEFAULT);
		// Lock status follows the configuration and ignores bus writes
		repeat (4) begin
			{main_protect_cfg, secondary_protect_cfg, security_lock} <= $random(seed);
			reg_io(2'd0, fpm_pkg::OFS_MAIN_LOCK, $random(seed));
			reg_io(2'd0, fpm_pkg::OFS_SEC_LOCK, $random(seed));
			reg_io(2'd1, fpm_pkg::OFS_MAIN_LOCK, main_protect_cfg);
			reg_io(2'd1, fpm_pkg::OFS_SEC_LOCK, {security_lock, 3'h0, secondary_protect_cfg});
		end
		reg_io(2'd1, 8'h55, 8'h00);
		// Every map value against read and fetch strobes on main, secondary and SRAM
		for (int i = 0; i < 32; i++) begin
			reg_io(2'd0, fpm_pkg::OFS_SPACE_MAP, i[7:0]);
			reg_io(2'd1, fpm_pkg::OFS_SPACE_MAP, i[7:0]);
			for (int t = 0; t < 6; t++) begin
				sel(t % 3 == 0 ? 8'h01 : 8'h00, t % 3 == 1 ? 4'h1 : 4'h0, t % 3 == 2, 1'b0);
				acc(t < 3 ? 2'd1 : 2'd2, $random(seed), 8'h00);
				chk("map oe", data_oe, exp_oe(i[4:0], t >= 3, t % 3 == 2, t % 3 == 1, t % 3 == 0));
			end
		end
		// Random overlapping selects
		repeat (150) begin
			m = $random(seed) & 8'h1f;
			{r, f} = $random(seed);
			mm = $random(seed) % 3 == 0 ? 8'h00 : 8'h01 << ($random(seed) & 7);
			ss = $random(seed) % 2 == 0 ? 4'h0 : 4'h1 << ($random(seed) & 3);
			reg_io(2'd0, fpm_pkg::OFS_SPACE_MAP, m);
			sel(mm, ss, r, 1'b0);
			acc(f ? 2'd2 : 2'd1, $random(seed), 8'h00);
			chk("prio oe", data_oe, exp_oe(m[4:0], f, r, ss, mm));
		end
		reg_io(2'd0, fpm_pkg::OFS_SPACE_MAP, 8'h1f);
		main_protect_cfg <= 8'h01;
		// Program into a protected sector is dropped, data read back unchanged
		sel(8'h01, 4'h0, 1'b0, 1'b0);
		unlock();
		acc(2'd0, 16'h0000, fpm_pkg::CMD_PROGRAM);
		acc(2'd0, 16'h0123, 8'h5a);
		chk("protected start", {prog_start, 8'(n_prog)}, 16'h0000);
		chk("protected busy", flash_busy, 1'b0);
		acc(2'd1, 16'h0123, 8'h00);
		chk("verify", rdata, last_mem);
		// Unprotected program, reset ignored while it runs
		sel(8'h02, 4'h0, 1'b0, 1'b0);
		unlock();
		acc(2'd0, 16'h0000, fpm_pkg::CMD_PROGRAM);
		acc(2'd0, 16'h2345, 8'ha5);
		chk("prog start", {prog_start, op_data}, {1'b1, 8'ha5});
		chk("prog addr", op_addr, 16'h2345);
		acc(2'd0, 16'h2345, fpm_pkg::CMD_RESET);
		wait_busy(200, 260);
		// Error during program, then prefixed reset recovers late
		unlock();
		acc(2'd0, 16'h0000, fpm_pkg::CMD_PROGRAM);
		acc(2'd0, 16'h2346, 8'h3c);
		algo_error <= 1'b1;
		@(posedge clock);
		algo_error <= 1'b0;
		acc(2'd1, 16'h2346, 8'h00);
		chk("status error", {error_flag_bit, rdata[fpm_pkg::STAT_ERROR]}, 2'b11);
		unlock();
		acc(2'd0, 16'h2346, fpm_pkg::CMD_RESET);
		wait_busy(600, 640);
		// Sector erase aborted by a bare reset write
		sel(8'h04, 4'h0, 1'b0, 1'b0);
		unlock();
		acc(2'd0, 16'h0000, fpm_pkg::CMD_ERASE_SETUP);
		unlock();
		acc(2'd0, 16'h4000, fpm_pkg::CMD_SECTOR_ERASE);
		chk("erase mask", {erase_start, erase_mask}, {1'b1, 12'h004});
		acc(2'd0, 16'h4000, fpm_pkg::CMD_RESET);
		wait_busy(600, 640);
		// Reset pin during program
		sel(8'h02, 4'h0, 1'b0, 1'b0);
		unlock();
		acc(2'd0, 16'h0000, fpm_pkg::CMD_PROGRAM);
		acc(2'd0, 16'h2347, 8'h0f);
		reset_pulse <= 1'b1;
		repeat (625) @(posedge clock);
		reset_pulse <= 1'b0;
		wait_busy(600, 640);
		chk("prog count", n_prog, 3);
		// Short pin pulse while idle keeps read mode at once
		@(posedge clock);
		reset_pulse <= 1'b1;
		@(posedge clock);
		reset_pulse <= 1'b0;
		#1 chk("pin idle", flash_read_mode, 1'b1);
		// Split spaces: fetches reach main flash, data reads do not
		reg_io(2'd0, fpm_pkg::OFS_SPACE_MAP, 8'h0c);
		sel(8'h02, 4'h0, 1'b0, 1'b0);
		acc(2'd2, 16'h1000, 8'h00);
		chk("split fetch", data_oe, 1'b1);
		acc(2'd1, 16'h1000, 8'h00);
		chk("split read", data_oe, 1'b0);
		sel(8'h00, 4'h1, 1'b0, 1'b0);
		acc(2'd1, 16'h1000, 8'h00);
		chk("split sec read", data_oe, 1'b1);
		stop_test();
	end
endmodule // fpm_top_tb_top
